// file: fcpl_consts.svh
// Constants of the flash command protection and lock block
`ifndef FCPL_CONSTS_SVH
`define FCPL_CONSTS_SVH
// ==========================================================
// Register byte offsets
`define FCPL_OFS_PE_PROTECT 8'h00
`define FCPL_OFS_MODE_ENTRY 8'h04
`define FCPL_OFS_BLOCK_PROTECT 8'h08
`define FCPL_OFS_ACCESS_STATUS 8'h0C
`define FCPL_OFS_IRQ_ENABLE 8'h10
`define FCPL_OFS_SEQ_STATUS 8'h14
`define FCPL_OFS_CMD_AREA 8'h18
`define FCPL_OFS_START_ADDR 8'h1C
`define FCPL_OFS_END_ADDR 8'h20
`define FCPL_OFS_BLANK_DIR 8'h24
`define FCPL_OFS_LOCK_STATUS 8'h28
// ==========================================================
// Field positions
`define FCPL_SS_PSUSP 10
`define FCPL_SS_ESUSP 11
`define FCPL_SS_READY 15
`define FCPL_AS_DFA 3
`define FCPL_AS_CFA 4
`define FCPL_AS_COMMAND_LOCK_FLAG 7
`define FCPL_IE_LOCK 7
`define FCPL_BLK_LSB 16
// ==========================================================
// Error flag indices
`define FCPL_NFLAGS 10
`define FCPL_F_ILL 0
`define FCPL_F_ERS 1
`define FCPL_F_PRG 2
`define FCPL_F_CTL 3
`define FCPL_F_WEE 4
`define FCPL_F_CFG 5
`define FCPL_F_TBL 6
`define FCPL_F_RAM 7
`define FCPL_F_CFA 8
`define FCPL_F_DFA 9
`define FCPL_CLR_STATUS_MASK 10'h007
`define FCPL_CLR_ALL_MASK 10'h0FF
`define FCPL_LOCK_MASK 10'h39F
// ==========================================================
// Values and command codes
`define FCPL_KEY_ENABLE 2'h1
`define FCPL_MODE_READ 16'h0000
`define FCPL_MODE_CODE 16'h0001
`define FCPL_MODE_DATA 16'h0080
`define FCPL_MODE_BAD 16'hAA81
`define FCPL_C_PROGRAM 8'hE8
`define FCPL_C_ERASE 8'h20
`define FCPL_C_LOCKPROG 8'h77
`define FCPL_C_BLANK 8'h71
`define FCPL_C_CONFIG 8'h40
`define FCPL_C_SUSPEND 8'hB0
`define FCPL_C_RESUME 8'hD0
`define FCPL_C_STATCLR 8'h50
`define FCPL_C_FSTOP 8'hB3
`define FCPL_C_FINAL 8'hD0
`define FCPL_N_MAX 8'h40
`define FCPL_CODE_LIMIT 24'h100000
`define FCPL_DATA_LIMIT 24'h010000
`define FCPL_CFG_A0 24'h000040
`define FCPL_CFG_A1 24'h000050
`define FCPL_CFG_A2 24'h000060
`define FCPL_LOCK_RESET 16'hFFFF
`define FCPL_RESP_OKAY 2'h0
`define FCPL_RESP_SLVERR 2'h2
`endif

// file: fcpl_pkg.sv
// Types of the flash command protection and lock block
package fcpl_pkg;
	// ==========================================================
	// Sequencer states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_WAIT_N = 5'h02,
		ST_WAIT_FINAL = 5'h04,
		ST_BUSY = 5'h08,
		ST_SUSP = 5'h10
	} fcpl_state_t;
	// Operation kinds handed to the array
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_PROGRAM = 3'h1,
		OP_ERASE = 3'h2,
		OP_LOCKPROG = 3'h3,
		OP_BLANK = 3'h4,
		OP_CONFIG = 3'h5
	} fcpl_op_t;
endpackage

// file: fcpl_flag_if.sv
// Interface between command control and the sticky error flag store
`timescale 1ns/10ps
`include "fcpl_consts.svh"
interface fcpl_flag_if;
	logic [`FCPL_NFLAGS-1:0] set_vec;
	logic clr_status;
	logic clr_all;
	logic [1:0] clr_access;
	logic [`FCPL_NFLAGS-1:0] flags;
	logic command_lock_flag;
	modport ctrl (output set_vec, clr_status, clr_all, clr_access, input flags, command_lock_flag);
	modport store (input set_vec, clr_status, clr_all, clr_access, output flags, command_lock_flag);
endinterface

// file: fcpl_err_flags.sv
// Sticky error flags and the derived command-lock flag
`timescale 1ns/10ps
`include "fcpl_consts.svh"
module fcpl_err_flags
	import fcpl_pkg::*;
(
	input wire logic aclk, // Flash clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic ce, // Clock enable
	fcpl_flag_if.store fi // Flag set and clear
);
	logic [`FCPL_NFLAGS-1:0] flags_ff;
	logic [`FCPL_NFLAGS-1:0] clr_mask;

	// ==========================================================
	// Clear sources; forced stop leaves the access violations alone
	always_comb begin
		clr_mask = {fi.clr_access, 8'h00};
		if (fi.clr_status) begin
			clr_mask = clr_mask | `FCPL_CLR_STATUS_MASK;
		end
		if (fi.clr_all) begin
			clr_mask = clr_mask | `FCPL_CLR_ALL_MASK;
		end
	end

	// Set beats clear so an event in the clear cycle survives
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_ff <= 10'h000;
		end else if (ce) begin
			flags_ff <= (flags_ff & ~clr_mask) | fi.set_vec;
		end
	end

	assign fi.flags = flags_ff;
	assign fi.command_lock_flag = |(flags_ff & `FCPL_LOCK_MASK);
endmodule

// file: fcpl_top.sv
// Flash command protection, error detection and command lock with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "fcpl_consts.svh"
module fcpl_top
	import fcpl_pkg::*;
(
	input wire logic aclk, // Flash clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic ce, // Clock enable
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic op_done, // Array finished or reached suspend
	input wire logic ev_erase_fail, // Erase failure pulse
	input wire logic ev_program_fail, // Program failure pulse
	input wire logic ev_ctrl_error, // Controller processing error
	input wire logic ev_ram_ecc, // Firmware RAM double-bit error
	input wire logic ev_cfg_ecc, // Configuration value double-bit error
	input wire logic ev_tbl_ecc, // Parameter table double-bit error
	output logic pe_start, // Start operation pulse
	output logic [2:0] pe_op, // Operation kind
	output logic [23:0] pe_addr, // Operation start address
	output logic pe_suspend, // Suspend request pulse
	output logic pe_resume, // Resume request pulse
	output logic pe_abort, // Forced stop pulse
	output logic flash_access_error_irq // Access error interrupt
);
	// ==========================================================
	// Declarations
	fcpl_flag_if fi ();
	fcpl_state_t state_ff, nxt_state;
	fcpl_op_t op_ff, nxt_op;
	logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff, rd_mux, merged;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [1:0] write_enable_key_ff;
	logic [15:0] mode_entry_ff, mode_snap_ff, lock_bits_ff;
	logic lock_override_ff, lock_irq_enable_ff, blank_dir_ff;
	logic [23:0] start_addr_ff, end_addr_ff;
	logic susp_pend_ff, erase_suspended_flag_ff, program_suspended_flag_ff, irq_ff;
	logic pe_start_ff, pe_suspend_ff, pe_resume_ff, pe_abort_ff;
	logic [2:0] pe_op_ff;
	logic [23:0] pe_addr_ff;
	logic wr_fire, ar_fire, cmd_wr, cmd_rd, mode_wr, ready, code_mode, data_mode;
	logic do_start, do_suspend, do_resume, do_fstop, do_clr_status, op_finish;
	logic [7:0] cmd_byte;
	logic [`FCPL_NFLAGS-1:0] set_vec;

	// Merge write data into a register by byte strobes
	function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Offsets with a register behind them
	function automatic logic addr_mapped(input logic [7:0] a);
		return (a == `FCPL_OFS_PE_PROTECT) || (a == `FCPL_OFS_MODE_ENTRY) ||
			(a == `FCPL_OFS_BLOCK_PROTECT) || (a == `FCPL_OFS_ACCESS_STATUS) ||
			(a == `FCPL_OFS_IRQ_ENABLE) || (a == `FCPL_OFS_SEQ_STATUS) ||
			(a == `FCPL_OFS_CMD_AREA) || (a == `FCPL_OFS_START_ADDR) ||
			(a == `FCPL_OFS_END_ADDR) || (a == `FCPL_OFS_BLANK_DIR) ||
			(a == `FCPL_OFS_LOCK_STATUS);
	endfunction

	// ==========================================================
	// AXI4-Lite write channel; address and data taken in either order
	assign s_axi_awready = ce && !aw_hold_ff && !bvalid_ff;
	assign s_axi_wready = ce && !w_hold_ff && !bvalid_ff;
	assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
	assign merged = wmask(wdata_ff & 32'h0, wdata_ff, wstrb_ff);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `FCPL_RESP_OKAY;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= addr_mapped(awaddr_ff) ? `FCPL_RESP_OKAY : `FCPL_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// ==========================================================
	// AXI4-Lite read channel; one read outstanding
	assign s_axi_arready = ce && !rvalid_ff;
	assign ar_fire = s_axi_arvalid && s_axi_arready;
	always_comb begin
		rd_mux = 32'h0;
		case (s_axi_araddr)
			`FCPL_OFS_PE_PROTECT: rd_mux = {30'h0, write_enable_key_ff};
			`FCPL_OFS_MODE_ENTRY: rd_mux = {16'h0, mode_entry_ff};
			`FCPL_OFS_BLOCK_PROTECT: rd_mux = {31'h0, lock_override_ff};
			`FCPL_OFS_ACCESS_STATUS: rd_mux = (32'(fi.command_lock_flag) << `FCPL_AS_COMMAND_LOCK_FLAG) |
				(32'(fi.flags[`FCPL_F_CFA]) << `FCPL_AS_CFA) |
				(32'(fi.flags[`FCPL_F_DFA]) << `FCPL_AS_DFA);
			`FCPL_OFS_IRQ_ENABLE: rd_mux = 32'(lock_irq_enable_ff) << `FCPL_IE_LOCK;
			`FCPL_OFS_SEQ_STATUS: rd_mux = {24'h0, fi.flags[7:0]} |
				(32'(ready) << `FCPL_SS_READY) |
				(32'(erase_suspended_flag_ff) << `FCPL_SS_ESUSP) |
				(32'(program_suspended_flag_ff) << `FCPL_SS_PSUSP);
			`FCPL_OFS_START_ADDR: rd_mux = {8'h0, start_addr_ff};
			`FCPL_OFS_END_ADDR: rd_mux = {8'h0, end_addr_ff};
			`FCPL_OFS_BLANK_DIR: rd_mux = {31'h0, blank_dir_ff};
			`FCPL_OFS_LOCK_STATUS: rd_mux = {16'h0, lock_bits_ff};
			default: rd_mux = 32'h0; // Command area and holes read as zero
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= `FCPL_RESP_OKAY;
		end else if (ce) begin
			if (ar_fire) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= rd_mux;
				rresp_ff <= addr_mapped(s_axi_araddr) ? `FCPL_RESP_OKAY : `FCPL_RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// ==========================================================
	// Software registers
	assign cmd_wr = wr_fire && (awaddr_ff == `FCPL_OFS_CMD_AREA);
	assign cmd_rd = ar_fire && (s_axi_araddr == `FCPL_OFS_CMD_AREA);
	assign mode_wr = wr_fire && (awaddr_ff == `FCPL_OFS_MODE_ENTRY);
	assign cmd_byte = wdata_ff[7:0];
	assign code_mode = (mode_entry_ff == `FCPL_MODE_CODE);
	assign data_mode = (mode_entry_ff == `FCPL_MODE_DATA);
	assign ready = (state_ff != ST_BUSY);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			write_enable_key_ff <= 2'h0;
			mode_entry_ff <= `FCPL_MODE_READ;
			lock_override_ff <= 1'b0;
			lock_irq_enable_ff <= 1'b0;
			start_addr_ff <= 24'h0;
			end_addr_ff <= 24'h0;
			blank_dir_ff <= 1'b0;
		end else if (ce && wr_fire) begin
			case (awaddr_ff)
				`FCPL_OFS_PE_PROTECT: write_enable_key_ff <= merged[1:0] | write_enable_key_ff &
					{2{!wstrb_ff[0]}};
				`FCPL_OFS_MODE_ENTRY: begin
					// The bad pattern is refused and only flags an error
					if (wmask({16'h0, mode_entry_ff}, wdata_ff, wstrb_ff) !=
						{16'h0, `FCPL_MODE_BAD}) begin
						mode_entry_ff <= 16'(wmask({16'h0, mode_entry_ff}, wdata_ff, wstrb_ff));
					end
				end
				`FCPL_OFS_BLOCK_PROTECT: if (wstrb_ff[0]) lock_override_ff <= wdata_ff[0];
				`FCPL_OFS_IRQ_ENABLE: if (wstrb_ff[0]) lock_irq_enable_ff <=
					wdata_ff[`FCPL_IE_LOCK];
				`FCPL_OFS_START_ADDR: start_addr_ff <= 24'(wmask({8'h0, start_addr_ff}, wdata_ff,
					wstrb_ff));
				`FCPL_OFS_END_ADDR: end_addr_ff <= 24'(wmask({8'h0, end_addr_ff}, wdata_ff,
					wstrb_ff));
				`FCPL_OFS_BLANK_DIR: if (wstrb_ff[0]) blank_dir_ff <= wdata_ff[0];
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Command decode, protection checks and error events
	always_comb begin
		set_vec = 10'h000;
		nxt_state = state_ff;
		nxt_op = op_ff;
		do_start = 1'b0;
		do_suspend = 1'b0;
		do_resume = 1'b0;
		do_fstop = 1'b0;
		do_clr_status = 1'b0;
		op_finish = 1'b0;
		set_vec[`FCPL_F_ERS] = ev_erase_fail;
		set_vec[`FCPL_F_PRG] = ev_program_fail;
		set_vec[`FCPL_F_CTL] = ev_ctrl_error;
		set_vec[`FCPL_F_RAM] = ev_ram_ecc;
		set_vec[`FCPL_F_CFG] = ev_cfg_ecc;
		set_vec[`FCPL_F_TBL] = ev_tbl_ecc;
		if (cmd_rd || (mode_wr && wmask({16'h0, mode_entry_ff}, wdata_ff, wstrb_ff) ==
			{16'h0, `FCPL_MODE_BAD})) begin
			set_vec[`FCPL_F_ILL] = 1'b1;
		end
		// Array completion; a lock taken meanwhile cancels the suspend
		if (state_ff == ST_BUSY && op_done) begin
			op_finish = !(susp_pend_ff && !fi.command_lock_flag);
			nxt_state = op_finish ? ST_IDLE : ST_SUSP;
		end
		if (cmd_wr) begin
			if (mode_entry_ff == `FCPL_MODE_READ) begin
				set_vec[`FCPL_F_ILL] = 1'b1;
			end else if (cmd_byte == `FCPL_C_FSTOP) begin
				do_fstop = 1'b1;
				nxt_state = ST_IDLE;
				nxt_op = OP_NONE;
			end else if (fi.command_lock_flag) begin
				if (cmd_byte == `FCPL_C_STATCLR && ready && !fi.flags[`FCPL_F_CFA] &&
					!fi.flags[`FCPL_F_DFA]) begin
					do_clr_status = 1'b1;
					if (state_ff != ST_BUSY && state_ff != ST_SUSP) nxt_state = ST_IDLE;
				end else begin
					set_vec[`FCPL_F_ILL] = 1'b1;
				end
			end else begin
				case (state_ff)
					ST_IDLE: begin
						case (cmd_byte)
							`FCPL_C_PROGRAM: begin
								nxt_op = OP_PROGRAM;
								nxt_state = ST_WAIT_N;
							end
							`FCPL_C_CONFIG: begin
								nxt_op = OP_CONFIG;
								nxt_state = ST_WAIT_N;
							end
							`FCPL_C_ERASE: begin
								nxt_op = OP_ERASE;
								nxt_state = ST_WAIT_FINAL;
							end
							`FCPL_C_LOCKPROG: begin
								nxt_op = OP_LOCKPROG;
								nxt_state = ST_WAIT_FINAL;
							end
							`FCPL_C_BLANK: begin
								nxt_op = OP_BLANK;
								nxt_state = ST_WAIT_FINAL;
							end
							`FCPL_C_STATCLR: do_clr_status = 1'b1;
							default: set_vec[`FCPL_F_ILL] = 1'b1;
						endcase
					end
					ST_WAIT_N: begin
						if (cmd_byte == 8'h00 || cmd_byte > `FCPL_N_MAX) begin
							set_vec[`FCPL_F_ILL] = 1'b1;
							nxt_state = ST_IDLE;
						end else begin
							nxt_state = ST_WAIT_FINAL;
						end
					end
					ST_WAIT_FINAL: begin
						nxt_state = ST_IDLE;
						if (cmd_byte != `FCPL_C_FINAL) begin
							set_vec[`FCPL_F_ILL] = 1'b1;
						end else if ((op_ff == OP_BLANK && !data_mode) ||
							((op_ff == OP_LOCKPROG || op_ff == OP_CONFIG) && !code_mode)) begin
							set_vec[`FCPL_F_ILL] = 1'b1;
						end else if (code_mode && op_ff != OP_CONFIG &&
							start_addr_ff >= `FCPL_CODE_LIMIT) begin
							set_vec[`FCPL_F_ILL] = 1'b1;
							set_vec[`FCPL_F_CFA] = 1'b1;
						end else if ((data_mode && start_addr_ff >= `FCPL_DATA_LIMIT) ||
							(op_ff == OP_CONFIG && start_addr_ff != `FCPL_CFG_A0 &&
							start_addr_ff != `FCPL_CFG_A1 && start_addr_ff != `FCPL_CFG_A2))
							begin
							set_vec[`FCPL_F_ILL] = 1'b1;
							set_vec[`FCPL_F_DFA] = 1'b1;
						end else if (op_ff == OP_BLANK && (blank_dir_ff ?
							(start_addr_ff < end_addr_ff) : (start_addr_ff > end_addr_ff)))
							begin
							set_vec[`FCPL_F_ILL] = 1'b1;
						end else if (op_ff != OP_BLANK &&
							write_enable_key_ff != `FCPL_KEY_ENABLE) begin
							set_vec[`FCPL_F_WEE] = 1'b1;
						end else if (code_mode && !lock_override_ff &&
							!lock_bits_ff[start_addr_ff[`FCPL_BLK_LSB +: 4]] &&
							(op_ff == OP_PROGRAM || op_ff == OP_ERASE ||
							op_ff == OP_LOCKPROG)) begin
							set_vec[`FCPL_F_ERS] = (op_ff == OP_ERASE);
							set_vec[`FCPL_F_PRG] = (op_ff != OP_ERASE);
						end else begin
							do_start = 1'b1;
							nxt_state = ST_BUSY;
						end
					end
					ST_BUSY: begin
						if (cmd_byte == `FCPL_C_SUSPEND && !susp_pend_ff) begin
							do_suspend = 1'b1;
						end else begin
							set_vec[`FCPL_F_ILL] = 1'b1;
						end
					end
					ST_SUSP: begin
						if (cmd_byte == `FCPL_C_RESUME && mode_entry_ff == mode_snap_ff) begin
							do_resume = 1'b1;
							nxt_state = ST_BUSY;
						end else if (cmd_byte == `FCPL_C_STATCLR) begin
							do_clr_status = 1'b1;
						end else begin
							set_vec[`FCPL_F_ILL] = 1'b1;
						end
					end
					default: begin
						set_vec[`FCPL_F_ILL] = 1'b1;
						nxt_state = ST_IDLE;
					end
				endcase
			end
		end
	end

	// Flag store hookup; violation flags clear by writing zero
	assign fi.set_vec = set_vec;
	assign fi.clr_status = do_clr_status;
	assign fi.clr_all = do_fstop;
	assign fi.clr_access = (wr_fire && awaddr_ff == `FCPL_OFS_ACCESS_STATUS && wstrb_ff[0]) ?
		{!wdata_ff[`FCPL_AS_DFA], !wdata_ff[`FCPL_AS_CFA]} : 2'h0;
	fcpl_err_flags u_flags (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.fi(fi)
	);

	// ==========================================================
	// Sequencer state, suspend bookkeeping and stored lock bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= ST_IDLE;
			op_ff <= OP_NONE;
			susp_pend_ff <= 1'b0;
			mode_snap_ff <= `FCPL_MODE_READ;
			erase_suspended_flag_ff <= 1'b0;
			program_suspended_flag_ff <= 1'b0;
			lock_bits_ff <= `FCPL_LOCK_RESET;
		end else if (ce) begin
			state_ff <= nxt_state;
			op_ff <= nxt_op;
			if (do_fstop || do_resume || op_finish) begin
				susp_pend_ff <= 1'b0;
			end else if (do_suspend) begin
				susp_pend_ff <= 1'b1;
				mode_snap_ff <= mode_entry_ff;
			end
			// Forced stop drops the suspended work for good
			if (do_fstop || do_resume) begin
				erase_suspended_flag_ff <= 1'b0;
				program_suspended_flag_ff <= 1'b0;
			end else if (state_ff == ST_BUSY && nxt_state == ST_SUSP) begin
				erase_suspended_flag_ff <= (op_ff == OP_ERASE);
				program_suspended_flag_ff <= (op_ff != OP_ERASE);
			end
			if (op_finish && op_ff == OP_ERASE) begin
				lock_bits_ff[start_addr_ff[`FCPL_BLK_LSB +: 4]] <= 1'b1;
			end else if (op_finish && op_ff == OP_LOCKPROG) begin
				lock_bits_ff[start_addr_ff[`FCPL_BLK_LSB +: 4]] <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Array control pulses and the interrupt level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pe_start_ff <= 1'b0;
			pe_suspend_ff <= 1'b0;
			pe_resume_ff <= 1'b0;
			pe_abort_ff <= 1'b0;
			pe_op_ff <= OP_NONE;
			pe_addr_ff <= 24'h0;
			irq_ff <= 1'b0;
		end else if (ce) begin
			pe_start_ff <= do_start;
			pe_suspend_ff <= do_suspend;
			pe_resume_ff <= do_resume;
			pe_abort_ff <= do_fstop;
			if (do_start) begin
				pe_op_ff <= op_ff;
				pe_addr_ff <= start_addr_ff;
			end
			irq_ff <= fi.command_lock_flag && lock_irq_enable_ff;
		end
	end
	assign pe_start = pe_start_ff;
	assign pe_op = pe_op_ff;
	assign pe_addr = pe_addr_ff;
	assign pe_suspend = pe_suspend_ff;
	assign pe_resume = pe_resume_ff;
	assign pe_abort = pe_abort_ff;
	assign flash_access_error_irq = irq_ff;
endmodule

// file: fcpl_top_asserts.sv
// Port assertions of the flash command protection and lock block
`timescale 1ns/10ps
module fcpl_chk(
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset
	input wire logic s_axi_bvalid, // Write done
	input wire logic pe_start, // Start
	input wire logic [2:0] pe_op, // Kind
	input wire logic pe_abort, // Abort
	input wire logic flash_access_error_irq // Irq
);
	// ========================
	// Start and abort pulses come only with a write; the irq holds until one
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_seen;
		$past(s_axi_bvalid);
	endsequence
	// Start and abort pulses rise on the same edge as the write response
	sequence wr_now;
		s_axi_bvalid;
	endsequence
	chk_start_cause: assert property (pe_start |-> wr_now)
		else $error("start without write");
	chk_start_pulse: assert property (pe_start |=> !pe_start)
		else $error("start too long");
	chk_op_kind: assert property (pe_start |-> pe_op inside {[3'h1:3'h5]})
		else $error("bad op");
	chk_abort_cause: assert property (pe_abort |-> wr_now)
		else $error("abort without write");
	chk_abort_pulse: assert property (pe_abort |=> !pe_abort)
		else $error("abort too long");
	chk_abort_alone: assert property (pe_abort |-> !pe_start)
		else $error("abort with start");
	chk_irq_drop: assert property ($fell(flash_access_error_irq) |-> wr_seen)
		else $error("irq fell alone");
	chk_irq_hold: assert property (flash_access_error_irq && !s_axi_bvalid |=>
		flash_access_error_irq) else $error("irq lost");
endmodule
bind fcpl_top fcpl_chk chk_i(
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid),
	.pe_start(pe_start),
	.pe_op(pe_op),
	.pe_abort(pe_abort),
	.flash_access_error_irq(flash_access_error_irq)
);

// file: fcpl_array_model.sv
// Flash array stand-in answering each started operation
`timescale 1ns/10ps
module fcpl_array_model(
	input wire logic aclk, // Clock
	input wire logic pe_start, // Start pulse
	output logic op_done // Done pulse
);
	logic [3:0] cnt_ff = 4'h0;
	// Long countdown so the busy state is seen
	always_ff @(posedge aclk) begin
		op_done <= cnt_ff == 4'h1;
		cnt_ff <= pe_start ? 4'hC : cnt_ff - {3'h0, cnt_ff != 4'h0};
	end
endmodule

// file: fcpl_top_tb.sv
// Testbench of the flash command protection and lock block
`timescale 1ns/10ps
module fcpl_top_tb;
	logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, pe_start, op_done, flash_access_error_irq;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [7:0] evb [6] = '{8'h02, 8'h04, 8'h08, 8'h80, 8'h20, 8'h40};
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic [5:0] ev = 6'h0;
	logic [33:0] d;
	int fail_count = 0, tests_run = 0, cyc = 0;
	// ========================
	// Design, array stand-in, clock and run ceiling
	fcpl_top uut(.*, .ce(1'h1), .s_axi_wstrb(4'hF), .s_axi_bready(1'h1), .s_axi_rready(1'h1),
		.s_axi_bresp(), .pe_op(), .pe_addr(), .pe_suspend(), .pe_resume(), .pe_abort(),
		.ev_erase_fail(ev[0]), .ev_program_fail(ev[1]), .ev_ctrl_error(ev[2]),
		.ev_ram_ecc(ev[3]), .ev_cfg_ecc(ev[4]), .ev_tbl_ecc(ev[5]));
	fcpl_array_model arr(.aclk, .pe_start, .op_done);
	initial forever #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	// ========================
	// Bus tasks; bready and rready stay high throughout
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		tests_run++;
		if (g !== e) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
			fail_count++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
	endtask
	// Command bytes, first byte highest, zero bytes skipped
	task automatic cm(input logic [31:0] s);
		for (int i = 3; i >= 0; i--) begin
			if (s[i*8 +: 8] != 8'h0) wr(8'h18, {24'h0, s[i*8 +: 8]});
		end
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = {s_axi_rresp, s_axi_rdata};
	endtask
	task automatic rc(input logic [7:0] a, input logic [33:0] e);
		rd(a);
		chk(d, e);
	endtask
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Scenarios; polling waits out the busy array
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		cm(32'hE8);
		rc(8'h0C, 34'h80);
		wr(8'h10, 32'h80);
		wr(8'h04, 32'h1);
		cm(32'h50E801D0);
		rc(8'h14, 34'h8010);
		chk({33'h0, flash_access_error_irq}, 34'h1);
		cm(32'h20);
		rc(8'h14, 34'h8011);
		cm(32'hB3);
		rc(8'h14, 34'h8000);
		chk({33'h0, flash_access_error_irq}, 34'h0);
		wr(8'h00, 32'h1);
		cm(32'h77D0);
		do rd(8'h14); while (!d[15]);
		cm(32'h20D0);
		rc(8'h14, 34'h8002);
		wr(8'h08, 32'h1);
		cm(32'h5020D0);
		do rd(8'h14); while (!d[15]);
		rc(8'h0C, 34'h0);
		wr(8'h1C, 32'h100000);
		cm(32'h20D0);
		rc(8'h0C, 34'h90);
		cm(32'h50);
		rc(8'h0C, 34'h90);
		wr(8'h0C, 32'h0);
		for (int i = 0; i < 6; i++) begin
			cm(32'hB3);
			ev[i] <= 1'h1;
			@(posedge aclk);
			ev[i] <= 1'h0;
			rc(8'h14, {26'h80, evb[i]});
		end
		rc(8'hFC, 34'h200000000);
		cm(32'hB3);
		rc(8'h18, 34'h0);
		rc(8'h14, 34'h8001);
		cm(32'hB3);
		wr(8'h04, 32'hAA81);
		rc(8'h04, 34'h1);
		rc(8'h14, 34'h8001);
		cm(32'hB3);
		cm(32'hE841);
		rc(8'h14, 34'h8001);
		// Lock while busy: the program runs on and a suspend is refused
		cm(32'hB3);
		wr(8'h1C, 32'h0);
		cm(32'hE801D0);
		rc(8'h14, 34'h0);
		cm(32'h20B0);
		do rd(8'h14); while (!d[15]);
		rc(8'h14, 34'h8001);
		// Forced stop after a finished suspend leaves nothing to resume
		cm(32'hB3);
		cm(32'hE801D0);
		cm(32'hB0);
		do rd(8'h14); while (!d[15]);
		rc(8'h14, 34'h8400);
		cm(32'hB3);
		cm(32'hD0);
		rc(8'h14, 34'h8001);
		cm(32'hB3);
		wr(8'h04, 32'h80);
		wr(8'h1C, 32'h10000);
		cm(32'h71D0);
		rc(8'h0C, 34'h88);
		finish_test();
	end
endmodule
